// >>> bench/core_model.sv
// Behavioural processor core: bus transactions and unit demand seen by the controller.
// Assumes one clock shared with the controller and requests coming from the bench.
`timescale 1ns/100ps

module core_model
	import pmc_pkg::*;
(
	input  wire logic               CLK,         // System clock
	input  wire logic               SYS_RST,     // Asynchronous reset, high
	input  wire logic               BUSY_GO,     // Start one bus transaction
	input  wire logic [3:0]         BUSY_LEN,    // Transaction length in cycles
	input  wire logic [UNITS_W-1:0] DEMAND_IN,   // Units the dispatcher wants
	input  wire logic               QUIESCE_ACK, // Acknowledge from the controller
	output logic                    BUS_BUSY,    // Transaction outstanding
	output logic [UNITS_W-1:0]      UNIT_DEMAND  // Registered unit demand
);
	logic [3:0] left_q;

	// No new transaction once quiesced, so the bus stays idle in nap and sleep
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			left_q      <= '0;
			UNIT_DEMAND <= '0;
		end else begin
			UNIT_DEMAND <= DEMAND_IN;
			if (BUSY_GO && !QUIESCE_ACK) left_q <= BUSY_LEN;
			else if (left_q != 4'h0) left_q <= left_q - 4'h1;
		end
	end

	// Busy while cycles of the transaction remain
	assign BUS_BUSY = (left_q != 4'h0);
endmodule : core_model

// >>> bench/power_mode_control_bench.sv
// Self-checking bench of the power-mode controller with a behavioural core beside it.
// Assumes CE held high; pins change only at clock edges and lag two sync cycles.
`timescale 1ns/100ps

module power_mode_control_bench;
	import pmc_pkg::*;
	logic                   clk, sys_rst, wr_s, rd_s, dec, busy_go, busy;
	logic [ADDR_W-1:0]      addr;
	logic [DATA_W-1:0]      wdata, rdata, v, seed;
	logic [PIN_W-1:0]       pin_v;
	logic [UNITS_W-1:0]     dem, dem_q;
	logic [3:0]             cm;
	outs_t                  pe;
	int                     error_cnt, comparisons;

	power_mode_control u_power_mode_control (.CLK(clk), .SYS_RST(sys_rst), .CE(1'b1),
		.ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
		.PIN_IN(pins_t'(pin_v)), .DEC_EXC(dec), .BUS_BUSY(busy), .UNIT_DEMAND(dem_q),
		.POWER_EN(pe));
	core_model u_core_model (.CLK(clk), .SYS_RST(sys_rst), .BUSY_GO(busy_go),
		.BUSY_LEN(4'h6), .DEMAND_IN(dem), .QUIESCE_ACK(pe.quiesce_ack), .BUS_BUSY(busy),
		.UNIT_DEMAND(dem_q));

	// Clock at 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(logic [31:0] seen, logic [31:0] exp, string m);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t %s seen %h want %h", $time, m, seen, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize

	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr

	task automatic rd(logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask : rd

	// Expected status word built from the bench's own state model
	task automatic st(int c, int p, logic a, string m);
		rd(STATUS_OFS, v);
		chk(v, {20'h0, seed[4:0], a, p[2:0], c[2:0]}, m);
	endtask : st

	// Whole-word update so the automatic index never sits on a non-blocking target
	task automatic pin(int b, logic l);
		@(posedge clk);
		pin_v <= l ? (pin_v | (PIN_W'(1) << b)) : (pin_v & ~(PIN_W'(1) << b));
		cyc(4);
	endtask : pin

	task automatic decx(); // Two-cycle decrementer exception
		@(posedge clk);
		dec <= 1'b1;
		repeat (2) @(posedge clk);
		dec <= 1'b0;
		cyc(2);
	endtask : decx

	task automatic wait_ack();
		for (int i = 0; i < 20; i++) begin
			cyc(1);
			if (pe.quiesce_ack === 1'b1) return;
		end
		error_cnt++;
		$display("mismatch t=%0t quiesce acknowledge never came", $time);
		summarize();
	endtask : wait_ack

	initial begin
		error_cnt = 0;
		comparisons = 0;
		seed = 32'h8444;
		{wr_s, rd_s, dec, busy_go, addr, wdata, dem} = '0;
		pin_v = {9'h0, seed[4:0]};
		cm = CORE_MULT_RST;
		sys_rst = 1'b1;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		cyc(4);
		// Reset values, straps, unmapped and read-only places
		rd(CORE_CFG_OFS, v);
		chk(v, {24'h0, cm, 4'h0}, "core cfg reset");
		rd(PERIPH_CTRL_OFS, v);
		chk(v, 32'h0, "periph reset");
		wr(4'hC, lfsr(seed));
		rd(4'hC, v);
		chk(v, 32'h0, "unmapped");
		wr(STATUS_OFS, 32'hFFF);
		st(0, 0, 1'b0, "status reset");
		chk(pe.unit_en, UNITS_ALL, "units on");
		chk(pe.pci_mult, seed[4:0], "pci mult");
		$display("test reset done");
		// Core doze, decrementer wake, state kept
		wr(CORE_CFG_OFS, {cm, 4'h1});
		cyc(2);
		st(1, 0, 1'b0, "doze");
		chk({pe.snoop_en, pe.dcache_en, pe.dec_en}, 3'h7, "doze units");
		decx();
		st(0, 0, 1'b0, "doze dec wake");
		rd(CORE_CFG_OFS, v);
		chk(v, {24'h0, cm, 4'h0}, "state kept");
		// Doze wake by each asynchronous source
		for (int b = 9; b < 14; b++) begin
			wr(CORE_CFG_OFS, {cm, 4'h1});
			cyc(2);
			pin(b, 1'b1);
			pin(b, 1'b0);
			st(0, 0, 1'b0, "doze pin wake");
		end
		$display("test doze done");
		// Nap waits for an idle bus before acknowledge
		@(posedge clk);
		busy_go <= 1'b1;
		@(posedge clk);
		busy_go <= 1'b0;
		wr(CORE_CFG_OFS, {cm, 4'h2});
		cyc(1);
		st(2, 0, 1'b0, "wait busy");
		wait_ack();
		cyc(2);
		st(3, 0, 1'b1, "nap");
		chk({pe.snoop_en, pe.dcache_en, pe.dec_en, pe.unit_en}, 7'h10, "nap units");
		decx();
		st(0, 0, 1'b0, "nap dec wake");
		$display("test nap done");
		// Core sleep, then peripheral sleep with refresh off
		wr(CORE_CFG_OFS, {cm, 4'h4});
		wait_ack();
		cyc(2);
		decx();
		st(4, 0, 1'b1, "sleep ignores dec");
		chk({pe.core_clk_en, pe.dec_en, pe.unit_en}, 6'h0, "sleep core");
		wr(PERIPH_CTRL_OFS, 32'h0C);
		cyc(3);
		st(4, 4, 1'b1, "periph sleep");
		chk({pe.pci_dec_en, pe.pci_arb_en, pe.refresh_en}, 3'h2, "sleep decode");
		chk({pe.pll_en, pe.mem_clk_en}, 2'h3, "sleep clocks");
		chk({pe.monitor_en, pe.embedded_interrupt_ctrl_en, pe.serial_en, pe.periph_logic_en}, 4'hE, "sleep periph");
		pin(5, 1'b1);
		st(4, 4, 1'b1, "sleep pci");
		pin(5, 1'b0);
		pin(8, 1'b1);
		pin(8, 1'b0);
		st(0, 0, 1'b0, "nmi wake");
		$display("test sleep done");
		// Peripheral nap serves a PCI access and naps again
		wr(PERIPH_CTRL_OFS, 32'h0);
		wr(CORE_CFG_OFS, {cm, 4'h2});
		wait_ack();
		cyc(2);
		wr(PERIPH_CTRL_OFS, 32'h2);
		cyc(3);
		st(3, 2, 1'b1, "periph nap");
		chk({pe.pci_dec_en, pe.pci_arb_en, pe.refresh_en}, 3'h7, "nap decode");
		chk({pe.periph_logic_en, pe.core_clk_en}, 2'h1, "nap clocks");
		pin(5, 1'b1);
		st(3, 3, 1'b1, "pci in nap");
		chk(pe.periph_logic_en, 1'b1, "svc logic on");
		pin(5, 1'b0);
		st(3, 2, 1'b1, "back to nap");
		pin(7, 1'b1);
		pin(7, 1'b0);
		st(0, 0, 1'b0, "bus req wake");
		$display("test periph nap done");
		// Peripheral nap refused with core awake; doze woken by PCI access
		wr(PERIPH_CTRL_OFS, 32'h2);
		cyc(3);
		st(0, 0, 1'b0, "nap refused");
		wr(PERIPH_CTRL_OFS, 32'h1);
		cyc(3);
		st(0, 1, 1'b0, "periph doze");
		chk(pe.pci_dec_en, 1'b1, "doze decode");
		pin(5, 1'b1);
		pin(5, 1'b0);
		st(0, 0, 1'b0, "pci wake");
		$display("test periph doze done");
		// On-demand power with a new core multiple
		cm = 4'h3;
		wr(CORE_CFG_OFS, {cm, 4'h8});
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			@(posedge clk);
			dem <= seed[11:8];
			cyc(3);
			chk(pe.unit_en, seed[11:8], "demand");
		end
		chk(pe.core_mult, cm, "core mult");
		$display("test demand done");
		summarize();
	end
endmodule : power_mode_control_bench

// >>> rtl/pmc_pkg.sv
// Constants, register layouts, state enums and carrier structs of the power-mode controller.
// Assumes one 100 MHz clock, and a simple strobe register port with 4-bit byte addresses.
// Contract
// - Separate doze, nap, sleep for core and periphery
// - Modes requested through core and peripheral registers
// - All state retained through every low-power mode
// - On-demand power gates core units by dispatch
// - Core doze keeps snoop, cache, decrementer running
// - Doze wakes on interrupts, decrementer, resets, check
// - Nap entered after quiesce acknowledge; decrementer wakes
// - Sleep stops everything; decrementer cannot wake it
// - Peripheral doze/nap keep decode, arbiter, refresh running
// - Peripheral wakes on bus request, NMI, interrupts, reset
// - Peripheral nap/sleep need core in nap/sleep
// - Peripheral sleep stops decode; refresh, PLL optional
// - PCI access in nap keeps quiesce acknowledge asserted
// - After nap PCI access, return to nap alone
// - Peripheral clock multiple chosen by five-bit straps
// - Memory clock same rate, synchronous to peripheral
// - Core clock is a multiple of peripheral clock
package pmc_pkg;

	// Register port geometry and field widths
	localparam int          ADDR_W          = 4;
	localparam int          DATA_W          = 32;
	localparam int          UNITS_W         = 4;
	localparam int          PLL_CFG_W       = 5;
	localparam int          CORE_MULT_W     = 4;

	// Register byte offsets
	localparam logic [3:0]  CORE_CFG_OFS    = 4'h0;
	localparam logic [3:0]  PERIPH_CTRL_OFS = 4'h4;
	localparam logic [3:0]  STATUS_OFS      = 4'h8;

	// Reset values and timing counts
	localparam logic [3:0]  CORE_MULT_RST   = 4'h2;
	localparam logic [1:0]  STRAP_WAIT      = 2'h2;
	localparam logic [3:0]  UNITS_ALL       = 4'hF;

	// Core power states
	typedef enum logic [2:0] {C_FULL, C_DOZE, C_WAIT, C_NAP, C_SLEEP} core_st_t;

	// Peripheral power states
	typedef enum logic [2:0] {P_FULL, P_DOZE, P_NAP, P_SVC, P_SLEEP} per_st_t;

	// core_hw_config_reg layout, low bit last
	typedef struct packed {
		logic [CORE_MULT_W-1:0] core_mult;
		logic                   dpm_en;
		logic                   sleep;
		logic                   nap;
		logic                   doze;
	} core_cfg_t;

	// periph_power_ctrl_reg layout, low bit last
	typedef struct packed {
		logic                   pll_off;
		logic                   refresh_off;
		logic                   sleep;
		logic                   nap;
		logic                   doze;
	} per_cfg_t;

	// Status register layout, low bit last
	typedef struct packed {
		logic [PLL_CFG_W-1:0]   pci_mult;
		logic                   quiesce_ack;
		per_st_t                per_st;
		core_st_t               core_st;
	} status_t;

	// Pin inputs, all asynchronous to CLK
	typedef struct packed {
		logic                   system_mgmt_interrupt;
		logic                   ext_int;
		logic                   machine_check;
		logic                   hard_rst;
		logic                   soft_rst;
		logic                   nmi;
		logic                   bus_req;
		logic                   embedded_interrupt_ctrl;
		logic                   pci_mem;
		logic [PLL_CFG_W-1:0]   pll_cfg;
	} pins_t;

	localparam int          PIN_W           = $bits(pins_t);

	// Power and clock enables driven to the rest of the chip
	typedef struct packed {
		logic                   snoop_en;
		logic                   dcache_en;
		logic                   dec_en;
		logic                   core_clk_en;
		logic [UNITS_W-1:0]     unit_en;
		logic                   quiesce_ack;
		logic                   pci_dec_en;
		logic                   pci_arb_en;
		logic                   refresh_en;
		logic                   monitor_en;
		logic                   embedded_interrupt_ctrl_en;
		logic                   serial_en;
		logic                   pll_en;
		logic                   mem_clk_en;
		logic                   periph_logic_en;
		logic [PLL_CFG_W-1:0]   pci_mult;
		logic [CORE_MULT_W-1:0] core_mult;
	} outs_t;

	// Whole state of the controller
	typedef struct packed {
		core_cfg_t              core_cfg;
		per_cfg_t               per_cfg;
		core_st_t               core_st;
		per_st_t                per_st;
		logic [1:0]             strap_cnt;
		logic                   strap_done;
		logic [DATA_W-1:0]      rdata;
		outs_t                  outs;
	} ctl_t;

	localparam core_cfg_t   CORE_CFG_RST = '{core_mult: CORE_MULT_RST, default: 1'b0};

	localparam outs_t       OUTS_RST = '{
		snoop_en: 1'b1, dcache_en: 1'b1, dec_en: 1'b1, core_clk_en: 1'b1,
		unit_en: UNITS_ALL, quiesce_ack: 1'b0, pci_dec_en: 1'b1, pci_arb_en: 1'b1,
		refresh_en: 1'b1, monitor_en: 1'b1, embedded_interrupt_ctrl_en: 1'b1, serial_en: 1'b1,
		pll_en: 1'b1, mem_clk_en: 1'b1, periph_logic_en: 1'b1,
		pci_mult: '0, core_mult: CORE_MULT_RST};

	localparam ctl_t        CTL_RST = '{
		core_cfg: CORE_CFG_RST, per_cfg: '0, core_st: C_FULL, per_st: P_FULL,
		strap_cnt: '0, strap_done: 1'b0, rdata: '0, outs: OUTS_RST};

endpackage : pmc_pkg

// >>> rtl/pmc_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes every bit is an independent level; the clock enable freezes both stages.
`timescale 1ns/100ps

module pmc_sync #(
	parameter int W = 1
) (
	input  wire logic         CLK,     // System clock
	input  wire logic         SYS_RST, // Asynchronous reset, high
	input  wire logic         CE,      // Clock enable
	input  wire logic [W-1:0] D,       // Asynchronous levels
	output logic      [W-1:0] Q        // Synchronised levels
);

	logic [W-1:0] meta_q;

	// One pair of flops per bit; the first stage feeds only the second
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge CLK or posedge SYS_RST) begin
			if (SYS_RST) begin
				meta_q[i] <= 1'b0;
				Q[i]      <= 1'b0;
			end else if (CE) begin
				meta_q[i] <= D[i];
				Q[i]      <= meta_q[i];
			end
		end
	end

endmodule : pmc_sync

// >>> rtl/power_mode_control.sv
// Power-mode controller: core and peripheral power states, quiesce handshake, clock enables.
// Assumes pins arrive asynchronously; DEC_EXC, BUS_BUSY and UNIT_DEMAND come from CLK logic.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps

module power_mode_control
	import pmc_pkg::*;
(
	input  wire logic                CLK,         // 100 MHz system clock
	input  wire logic                SYS_RST,     // Asynchronous reset, high
	input  wire logic                CE,          // Clock enable, low freezes all
	input  wire logic [ADDR_W-1:0]   ADDR,        // Register byte address
	input  wire logic [DATA_W-1:0]   WDATA,       // Register write data
	input  wire logic                WR,          // Write strobe
	input  wire logic                RD,          // Read strobe
	output logic      [DATA_W-1:0]   RDATA,       // Read data, cycle after RD
	input  wire pins_t               PIN_IN,      // Asynchronous wake pins and straps
	input  wire logic                DEC_EXC,     // Decrementer exception
	input  wire logic                BUS_BUSY,    // Processor bus transaction open
	input  wire logic [UNITS_W-1:0]  UNIT_DEMAND, // Units wanted by dispatch
	output outs_t                    POWER_EN     // Power and clock enables
);

	pins_t pin;
	ctl_t  s;
	ctl_t  n;

	// Core wake sources common to every reduced core mode
	function automatic logic core_async_wake(input pins_t p);
		return p.system_mgmt_interrupt | p.ext_int | p.hard_rst | p.soft_rst | p.machine_check;
	endfunction : core_async_wake

	// Peripheral wake sources common to every reduced peripheral mode
	function automatic logic periph_wake(input pins_t p);
		return p.bus_req | p.nmi | p.embedded_interrupt_ctrl | p.hard_rst;
	endfunction : periph_wake

	// Pin synchroniser
	pmc_sync #(
		.W       (PIN_W)
	) u_sync (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.CE      (CE),
		.D       (PIN_IN),
		.Q       (pin)
	);

	logic      core_wr;
	logic      per_wr;
	core_cfg_t wcore;
	per_cfg_t  wper;
	logic      aw;
	logic      pw;
	logic      core_low;
	status_t   stat;

	// Decode of the register port
	always_comb begin
		core_wr = WR && (ADDR == CORE_CFG_OFS);
		per_wr  = WR && (ADDR == PERIPH_CTRL_OFS);
		wcore   = core_cfg_t'(WDATA[$bits(core_cfg_t)-1:0]);
		wper    = per_cfg_t'(WDATA[$bits(per_cfg_t)-1:0]);
		aw      = core_async_wake(pin);
		pw      = periph_wake(pin);
		core_low = (s.core_st == C_NAP) || (s.core_st == C_SLEEP);
		stat    = '{pci_mult: s.outs.pci_mult, quiesce_ack: s.outs.quiesce_ack,
		            per_st: s.per_st, core_st: s.core_st};
	end

	// Next state of the whole controller
	always_comb begin
		n = s;

		// Register writes; only the mode fields are ever touched by hardware
		if (core_wr) begin
			n.core_cfg = wcore;
		end
		if (per_wr) begin
			n.per_cfg = wper;
		end

		// Core power state machine
		unique case (s.core_st)
			C_FULL: begin
				if (core_wr && !aw) begin
					if (wcore.sleep || wcore.nap) begin
						n.core_st = C_WAIT;
					end else if (wcore.doze) begin
						n.core_st = C_DOZE;
					end
				end
			end
			C_DOZE: begin
				if (aw || DEC_EXC) begin
					n.core_st = C_FULL;
				end
			end
			C_WAIT: begin
				if (aw) begin
					n.core_st = C_FULL;
				end else if (s.outs.quiesce_ack) begin
					n.core_st = s.core_cfg.sleep ? C_SLEEP : C_NAP;
				end
			end
			C_NAP: begin
				if (aw || DEC_EXC || !s.outs.quiesce_ack) begin
					n.core_st = C_FULL;
				end
			end
			C_SLEEP: begin
				if (aw || !s.outs.quiesce_ack) begin
					n.core_st = C_FULL;
				end
			end
		endcase

		// A core wake retires the pending mode request
		if ((s.core_st != C_FULL) && (n.core_st == C_FULL)) begin
			n.core_cfg.doze  = 1'b0;
			n.core_cfg.nap   = 1'b0;
			n.core_cfg.sleep = 1'b0;
		end

		// Quiesce acknowledge: raise with bus idle, drop only on a real wake
		if (!s.outs.quiesce_ack) begin
			n.outs.quiesce_ack = (s.core_st == C_WAIT) && !BUS_BUSY && !pw;
		end else begin
			n.outs.quiesce_ack = !(pw || (s.core_st == C_FULL) || (s.core_st == C_DOZE));
		end

		// Peripheral power state machine
		unique case (s.per_st)
			P_FULL: begin
				if (!pw) begin
					if (s.per_cfg.sleep && core_low) begin
						n.per_st = P_SLEEP;
					end else if (s.per_cfg.nap && core_low) begin
						n.per_st = P_NAP;
					end else if (s.per_cfg.doze) begin
						n.per_st = P_DOZE;
					end
				end
			end
			P_DOZE: begin
				if (pw || pin.pci_mem) begin
					n.per_st = P_FULL;
				end
			end
			P_NAP: begin
				if (pw) begin
					n.per_st = P_FULL;
				end else if (pin.pci_mem) begin
					n.per_st = P_SVC;
				end
			end
			P_SVC: begin
				if (pw) begin
					n.per_st = P_FULL;
				end else if (!pin.pci_mem) begin
					n.per_st = P_NAP;
				end
			end
			P_SLEEP: begin
				if (pw) begin
					n.per_st = P_FULL;
				end
			end
		endcase

		// A peripheral wake retires its pending mode request
		if ((s.per_st != P_FULL) && (n.per_st == P_FULL)) begin
			n.per_cfg.doze  = 1'b0;
			n.per_cfg.nap   = 1'b0;
			n.per_cfg.sleep = 1'b0;
		end

		// Catch the PLL straps once the synchroniser holds valid levels
		if (!s.strap_done) begin
			if (s.strap_cnt == STRAP_WAIT) begin
				n.outs.pci_mult = pin.pll_cfg;
				n.strap_done    = 1'b1;
			end else begin
				n.strap_cnt = s.strap_cnt + 2'h1;
			end
		end

		// Core unit enables, aligned with the registered core state
		n.outs.snoop_en    = (n.core_st == C_FULL) || (n.core_st == C_DOZE) ||
		                     (n.core_st == C_WAIT);
		n.outs.dcache_en   = n.outs.snoop_en;
		n.outs.dec_en      = (n.core_st != C_SLEEP);
		n.outs.core_clk_en = (n.core_st != C_SLEEP);
		n.outs.core_mult   = n.core_cfg.core_mult;
		if (n.core_st != C_FULL) begin
			n.outs.unit_en = '0;
		end else if (n.core_cfg.dpm_en) begin
			n.outs.unit_en = UNIT_DEMAND;
		end else begin
			n.outs.unit_en = UNITS_ALL;
		end

		// Peripheral function enables, aligned with the registered peripheral state
		n.outs.pci_dec_en      = (n.per_st != P_SLEEP);
		n.outs.pci_arb_en      = 1'b1;
		n.outs.monitor_en      = 1'b1;
		n.outs.embedded_interrupt_ctrl_en         = 1'b1;
		n.outs.serial_en       = 1'b1;
		n.outs.refresh_en      = !((n.per_st == P_SLEEP) && n.per_cfg.refresh_off);
		n.outs.pll_en          = !((n.per_st == P_SLEEP) && n.per_cfg.pll_off);
		n.outs.mem_clk_en      = n.outs.pll_en;
		n.outs.periph_logic_en = (n.per_st == P_FULL) || (n.per_st == P_SVC);

		// Read data stands in the cycle after the strobe only
		n.rdata = '0;
		if (RD) begin
			unique case (ADDR)
				CORE_CFG_OFS:    n.rdata = DATA_W'(s.core_cfg);
				PERIPH_CTRL_OFS: n.rdata = DATA_W'(s.per_cfg);
				STATUS_OFS:      n.rdata = DATA_W'(stat);
				default:         n.rdata = '0;
			endcase
		end
	end

	// State register; nothing is cleared on mode entry, so wake resumes as left
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			s <= CTL_RST;
		end else if (CE) begin
			s <= n;
		end
	end

	// Outputs straight from the state register
	assign RDATA    = s.rdata;
	assign POWER_EN = s.outs;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST || !CE);

	// Nap or sleep is only reached with acknowledge already high
	a_lowpower_needs_ack: assert property (
		((s.core_st == C_NAP) || (s.core_st == C_SLEEP)) && ($past(s.core_st) == C_WAIT)
		|-> $past(s.outs.quiesce_ack))
		else $error("core entered nap or sleep without quiesce acknowledge");

	// Decrementer alone never wakes sleep
	a_sleep_ignores_dec: assert property (
		(s.core_st == C_SLEEP) && DEC_EXC && !aw && s.outs.quiesce_ack
		|=> (s.core_st == C_SLEEP))
		else $error("decrementer woke the core from sleep");

	// Dropped acknowledge wakes nap and sleep
	a_ack_drop_wakes: assert property (
		((s.core_st == C_NAP) || (s.core_st == C_SLEEP)) && !s.outs.quiesce_ack
		|=> (s.core_st == C_FULL))
		else $error("core stayed low after acknowledge dropped");

	// Doze leaves on any of its wake sources
	a_doze_wakes: assert property (
		(s.core_st == C_DOZE) && (aw || DEC_EXC) |=> (s.core_st == C_FULL) && !s.core_cfg.doze)
		else $error("core doze missed a wake event");

	// Peripheral nap or sleep only while the core is low
	a_per_gate: assert property (
		((s.per_st == P_NAP) || (s.per_st == P_SLEEP)) && ($past(s.per_st) == P_FULL)
		|-> ($past(s.core_st) == C_NAP) || ($past(s.core_st) == C_SLEEP))
		else $error("peripheral entered nap or sleep with core running");

	// PCI access in nap moves the periphery to service and keeps acknowledge
	a_pci_keeps_ack: assert property (
		(s.per_st == P_NAP) && pin.pci_mem && !pw && s.outs.quiesce_ack
		|=> (s.per_st == P_SVC) && s.outs.quiesce_ack)
		else $error("nap PCI access disturbed the acknowledge");

	// Finished PCI access returns to nap unprompted
	a_svc_returns: assert property (
		(s.per_st == P_SVC) && !pin.pci_mem && !pw |=> (s.per_st == P_NAP))
		else $error("peripheral did not return to nap");

	// Sleep stops address decode but keeps the arbiter
	a_sleep_decode: assert property (
		(s.per_st == P_SLEEP) |-> !POWER_EN.pci_dec_en && POWER_EN.pci_arb_en)
		else $error("decode or arbiter wrong in peripheral sleep");

	// Acknowledge rises only with the bus idle
	a_ack_bus_idle: assert property (
		$rose(s.outs.quiesce_ack) |-> !$past(BUS_BUSY) && ($past(s.core_st) == C_WAIT))
		else $error("acknowledge raised with bus busy");

	// Core units are gated off outside full power
	a_units_off: assert property (
		(s.core_st != C_FULL) |-> (POWER_EN.unit_en == '0))
		else $error("core units enabled in a reduced mode");

	// Read data is zero unless a read strobe preceded it
	a_read_slot: assert property (
		!$past(RD) |-> (RDATA == '0))
		else $error("read data outside its slot");

	// Any peripheral wake source brings full power back
	a_per_wake_full: assert property (
		(s.per_st != P_FULL) && pw |=> (s.per_st == P_FULL))
		else $error("peripheral missed a wake event");

	// PCI memory access ends peripheral doze
	a_doze_pci_wake: assert property (
		(s.per_st == P_DOZE) && pin.pci_mem |=> (s.per_st == P_FULL))
		else $error("PCI access did not wake peripheral doze");

	// Peripheral sleep ignores everything but its wake sources
	a_per_sleep_holds: assert property (
		(s.per_st == P_SLEEP) && !pw |=> (s.per_st == P_SLEEP))
		else $error("peripheral sleep left without a wake source");

	// Decrementer exception wakes core nap
	a_nap_dec_wake: assert property (
		(s.core_st == C_NAP) && DEC_EXC |=> (s.core_st == C_FULL))
		else $error("decrementer did not wake core nap");

	// Doze keeps snooping, cache and decrementer alive
	a_doze_units_on: assert property (
		(s.core_st == C_DOZE) |-> POWER_EN.snoop_en && POWER_EN.dcache_en && POWER_EN.dec_en)
		else $error("core doze idled a unit that must run");

	// Nap keeps the decrementer running, with snoop and cache off
	a_nap_dec_only: assert property (
		(s.core_st == C_NAP) |-> POWER_EN.dec_en && !POWER_EN.snoop_en && !POWER_EN.dcache_en)
		else $error("core nap enables are wrong");

	// Sleep stops the core clock and the decrementer
	a_sleep_all_off: assert property (
		(s.core_st == C_SLEEP) |-> !POWER_EN.core_clk_en && !POWER_EN.dec_en)
		else $error("core sleep left a unit running");

	// Acknowledge stands until a wake needs the core back
	a_ack_holds: assert property (
		s.outs.quiesce_ack && !pw && (s.core_st != C_FULL) && (s.core_st != C_DOZE)
		|=> s.outs.quiesce_ack)
		else $error("acknowledge dropped without a wake");

	// Main scenarios
	c_doze_trip: cover property ((s.core_st == C_DOZE) ##1 (s.core_st == C_FULL));
	c_per_sleep: cover property ((s.per_st == P_FULL) ##1 (s.per_st == P_SLEEP));
	c_core_nap: cover property ((s.core_st == C_WAIT) ##1 (s.core_st == C_NAP));
	c_core_sleep: cover property ((s.core_st == C_WAIT) ##1 (s.core_st == C_SLEEP));
	c_nap_service: cover property ((s.per_st == P_SVC) ##1 (s.per_st == P_NAP));

endmodule : power_mode_control
